/* aspf_defines.vh */
// aspf_defines.vh: register offsets, field positions, reset values and counts
// for the async serial port; assumes an APB slave with 32-bit aligned words.
// Functional notes
// - disabling the port lets the character in flight finish first.
// - frame is start, data lsb first, optional parity, then stop bits.
// - 5 to 8 data bits, one or two stop bits.
// - even, odd, stick or no parity on transmit and receive.
// - divisor is 16-bit integer plus 6-bit fraction in sixty-fourths.
// - divisor equals clock over sixteen times baud rate.
// - oversample tick at 16x baud; tx bit is sixteen ticks.
// - divisors and line control latch together only on line control write.
// - 16-entry tx fifo of bytes, 16-entry rx fifo with four status bits.
// - busy while tx fifo non-empty or a character is still shifting.
// - start bit resampled at eighth tick; high means false start.
// - data bits sampled every sixteenth tick, then parity checked.
// - stop bit must be high else framing error; push to rx fifo.
// - data read gives 8 data plus break, parity and framing flags; overrun bit reads 0; write queues 8 bits.
// - fifos act as one-entry holding registers until fifo enable set.
// - tx and rx thresholds select 1/8, 1/4, 1/2, 3/4 or 7/8.
// - both thresholds reset to half full.
// - seven masked events ORed onto one interrupt line.
// - writing 1 to clear bit clears raw and masked status, except rx and tx, which follow fifo level.
// - rx timeout when rx fifo holds data and 32 bit times idle.
// - rx timeout clears on drain or on its clear bit.
// - loopback routes transmitter output to receiver input.
`ifndef ASPF_DEFINES_VH
`define ASPF_DEFINES_VH
`define ASPF_OFS_DATA   12'h000
`define ASPF_OFS_RSR    12'h004
`define ASPF_OFS_FLAG   12'h018
`define ASPF_OFS_IBRD   12'h024
`define ASPF_OFS_FBRD   12'h028
`define ASPF_OFS_LCR    12'h02C
`define ASPF_OFS_CTL    12'h030
`define ASPF_OFS_IFLS   12'h034
`define ASPF_OFS_IM     12'h038
`define ASPF_OFS_RIS    12'h03C
`define ASPF_OFS_MIS    12'h040
`define ASPF_OFS_ICR    12'h044
// line control fields
`define ASPF_LCR_BRK    0
`define ASPF_LCR_PEN    1
`define ASPF_LCR_EPS    2
`define ASPF_LCR_STP2   3
`define ASPF_LCR_FEN    4
`define ASPF_LCR_WLS    5
`define ASPF_LCR_SPS    7
// control fields
`define ASPF_CTL_EN     0
`define ASPF_CTL_LBE    7
`define ASPF_CTL_TXE    8
`define ASPF_CTL_RXE    9
`define ASPF_CTL_RST    16'h0300
`define ASPF_IFLS_RST   6'h12
// interrupt bit positions
`define ASPF_IRQ_RX     4
`define ASPF_IRQ_TX     5
`define ASPF_IRQ_RT     6
`define ASPF_IRQ_FE     7
`define ASPF_IRQ_PE     8
`define ASPF_IRQ_BE     9
`define ASPF_IRQ_OE     10
`define ASPF_RT_BITS    32
`define ASPF_OVS        16
`endif

/* aspf_fifo.v */
// aspf_fifo.v: small synchronous fifo with registered read data.
// assumes the caller never pushes when full nor pops when empty.
`default_nettype none
module aspf_fifo #(
   parameter W = 8,
   parameter AW = 4
) (
   input  wire          mclk_i,
   input  wire          rstn_i,
   input  wire          one_i,
   input  wire          push_i,
   input  wire [W-1:0]  wdata_i,
   input  wire          pop_i,
   output reg  [W-1:0]  rdata_o,
   output wire [AW:0]   count_o,
   output wire          full_o,
   output wire          empty_o
);
   reg [W-1:0]  mem_q [0:(1<<AW)-1];
   reg [AW:0]   wp_q;
   reg [AW:0]   rp_q;
   assign count_o = wp_q - rp_q;
   assign empty_o = (count_o == {(AW+1){1'b0}});
   // one_i makes the fifo a one-entry holding register
   assign full_o  = one_i ? !empty_o : count_o[AW];
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
         rdata_o <= {W{1'b0}};
      end else begin
         if (push_i)
            wp_q <= wp_q + 1'b1;
         if (pop_i)
            rp_q <= rp_q + 1'b1;
         rdata_o <= mem_q[pop_i ? rp_q[AW-1:0] + 1'b1 : rp_q[AW-1:0]];
         if (push_i && (empty_o || (pop_i && count_o == 1)))
            rdata_o <= wdata_i;
      end
   end
   always @(posedge mclk_i) begin
      if (push_i)
         mem_q[wp_q[AW-1:0]] <= wdata_i;
   end
endmodule // aspf_fifo
`default_nettype wire

/* aspf_top.v */
// aspf_top.v: async serial port with fifos, fractional divisor, apb slave.
// assumes synchronous rx input and a single 20 MHz clock domain.
`include "aspf_defines.vh"
`default_nettype none
module aspf_top #(
   parameter AW = 4
) (
   input  wire        mclk_i,
   input  wire        rstn_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire        serial_in_line_i,
   output reg         serial_out_line_o,
   output wire        irq_o
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_STRT = 5'b00010;
   localparam ST_DATA = 5'b00100;
   localparam ST_PAR  = 5'b01000;
   localparam ST_STOP = 5'b10000;

   reg [15:0] integer_divisor_reg_q;
   reg [5:0]  fraction_divisor_reg_q;
   reg [7:0]  line_control_reg_q;
   reg [29:0] work_q;
   reg [15:0] port_control_reg_q;
   reg [5:0]  fifo_level_select_reg_q;
   reg [10:0] irq_mask_reg_q;
   reg [10:0] raw_q;
   reg [3:0]  receive_error_reg_q;

   wire wr = psel_i && penable_i && pwrite_i;
   wire rd = psel_i && penable_i && !pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;

   wire [15:0] divisor_integer_part = work_q[29:14];
   wire [5:0]  divisor_fraction_part = work_q[13:8];
   wire [7:0]  lcr = work_q[7:0];
   wire        fifo_on = lcr[`ASPF_LCR_FEN];
   wire [1:0]  wls = lcr[`ASPF_LCR_WLS+1:`ASPF_LCR_WLS];
   wire [3:0]  nbits = {2'b00, wls} + 4'd5;
   wire        port_on = port_control_reg_q[`ASPF_CTL_EN];
   wire        loopback_enable_bit = port_control_reg_q[`ASPF_CTL_LBE];

   reg [15:0] bcnt_q;
   reg [6:0]  facc_q;
   reg        oversample_tick;
   wire [6:0] facc_n = {1'b0, facc_q[5:0]} + {1'b0, divisor_fraction_part};
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         bcnt_q <= 16'h0001;
         facc_q <= 7'h00;
         oversample_tick <= 1'b0;
      end else begin
         oversample_tick <= 1'b0;
         if (bcnt_q <= 16'h0001) begin
            oversample_tick <= (divisor_integer_part != 16'h0000);
            facc_q <= facc_n;
            // carry out of the fraction stretches this period by a cycle
            bcnt_q <= divisor_integer_part + {15'h0000, facc_n[6]};
         end else begin
            bcnt_q <= bcnt_q - 16'h0001;
         end
      end
   end

   // fifos
   wire [7:0]  txf_q;
   wire [11:0] rxf_q;
   wire [AW:0] tx_cnt;
   wire [AW:0] rx_cnt;
   wire tx_full, tx_empty, rx_full, rx_empty;
   wire data_sel = (paddr_i == `ASPF_OFS_DATA);
   wire tx_push = wr && data_sel && !tx_full;
   reg  tx_pop;
   reg  rx_push;
   reg  [11:0] rx_word;
   wire rx_pop = rd && data_sel && !rx_empty;

   aspf_fifo #(.W(8), .AW(AW)) u_txf (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .one_i(!fifo_on),
      .push_i(tx_push), .wdata_i(pwdata_i[7:0]), .pop_i(tx_pop),
      .rdata_o(txf_q), .count_o(tx_cnt), .full_o(tx_full),
      .empty_o(tx_empty));
   aspf_fifo #(.W(12), .AW(AW)) u_rxf (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .one_i(!fifo_on),
      .push_i(rx_push && !rx_full), .wdata_i(rx_word), .pop_i(rx_pop),
      .rdata_o(rxf_q), .count_o(rx_cnt), .full_o(rx_full),
      .empty_o(rx_empty));

   // transmitter
   reg [4:0] ts_q;
   reg [3:0] tt_q;
   reg [3:0] ti_q;
   reg [7:0] tsh_q;
   reg       tpar_q;
   wire tx_en = port_on && port_control_reg_q[`ASPF_CTL_TXE];
   reg  tline;
   function par_bit;
      input [7:0] d;
      input [3:0] n;
      input [7:0] l;
      reg p;
      integer k;
      begin
         p = 1'b0;
         for (k = 0; k < 8; k = k + 1)
            if (k < n)
               p = p ^ d[k];
         if (l[`ASPF_LCR_SPS])
            par_bit = !l[`ASPF_LCR_EPS];
         else
            par_bit = l[`ASPF_LCR_EPS] ? p : !p;
      end
   endfunction
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         ts_q <= ST_IDLE;
         tt_q <= 4'h0;
         ti_q <= 4'h0;
         tsh_q <= 8'h00;
         tpar_q <= 1'b0;
         tline <= 1'b1;
         tx_pop <= 1'b0;
      end else begin
         tx_pop <= 1'b0;
         case (ts_q)
            ST_IDLE: begin
               tline <= 1'b1;
               if (tx_en && !tx_empty && !tx_pop && oversample_tick) begin
                  tsh_q <= txf_q;
                  tpar_q <= par_bit(txf_q, nbits, lcr);
                  tx_pop <= 1'b1;
                  tt_q <= 4'h0;
                  tline <= 1'b0;
                  ts_q <= ST_STRT;
               end
            end
            ST_STRT, ST_DATA, ST_PAR, ST_STOP: begin
               if (oversample_tick) begin
                  tt_q <= tt_q + 4'h1;
                  // one bit per sixteen ticks, lsb first
                  if (tt_q == 4'hF) begin
                     case (ts_q)
                        ST_STRT: begin
                           ts_q <= ST_DATA;
                           ti_q <= 4'h0;
                           tline <= tsh_q[0];
                        end
                        ST_DATA: begin
                           ti_q <= ti_q + 4'h1;
                           tsh_q <= {1'b0, tsh_q[7:1]};
                           if (ti_q == nbits - 4'h1) begin
                              ts_q <= lcr[`ASPF_LCR_PEN] ? ST_PAR : ST_STOP;
                              tline <= lcr[`ASPF_LCR_PEN] ? tpar_q : 1'b1;
                              ti_q <= 4'h0;
                           end else begin
                              tline <= tsh_q[1];
                           end
                        end
                        ST_PAR: begin
                           ts_q <= ST_STOP;
                           ti_q <= 4'h0;
                           tline <= 1'b1;
                        end
                        default: begin
                           if (ti_q == {3'b000, lcr[`ASPF_LCR_STP2]}) begin
                              ts_q <= ST_IDLE;
                           end
                           ti_q <= ti_q + 4'h1;
                        end
                     endcase
                  end
               end
            end
            default: ts_q <= ST_IDLE;
         endcase
      end
   end
   always @(posedge mclk_i) begin
      if (!rstn_i)
         serial_out_line_o <= 1'b1;
      else
         serial_out_line_o <= tline && !lcr[`ASPF_LCR_BRK];
   end
   wire busy = !tx_empty || (ts_q != ST_IDLE);

   // receiver
   // loopback select
   wire rxd = loopback_enable_bit ? serial_out_line_o : serial_in_line_i;
   reg       rxd_q;
   reg [4:0] rs_q;
   reg [3:0] rt_q;
   reg [3:0] ri_q;
   reg [7:0] rsh_q;
   reg       rpe_q;
   reg       rzero_q;
   reg       rdone;
   wire rx_en = port_on && port_control_reg_q[`ASPF_CTL_RXE];
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         rs_q <= ST_IDLE;
         rt_q <= 4'h0;
         ri_q <= 4'h0;
         rsh_q <= 8'h00;
         rpe_q <= 1'b0;
         rzero_q <= 1'b0;
         rxd_q <= 1'b1;
         rx_push <= 1'b0;
         rx_word <= 12'h000;
         rdone <= 1'b0;
      end else begin
         rx_push <= 1'b0;
         rdone <= 1'b0;
         if (oversample_tick) begin
            rxd_q <= rxd;
            rt_q <= rt_q + 4'h1;
            case (rs_q)
               ST_IDLE: begin
                  // only start a character while enabled
                  if (rx_en && rxd_q && !rxd) begin
                     rs_q <= ST_STRT;
                     rt_q <= 4'h1;
                  end
               end
               ST_STRT: begin
                  if (rt_q == 4'h7) begin
                     if (rxd) begin
                        rs_q <= ST_IDLE;
                     end else begin
                        rs_q <= ST_DATA;
                        rt_q <= 4'h0;
                        ri_q <= 4'h0;
                        rzero_q <= 1'b1;
                        rsh_q <= 8'h00;
                     end
                  end
               end
               ST_DATA, ST_PAR, ST_STOP: begin
                  if (rt_q == 4'hF) begin
                     rzero_q <= rzero_q && !rxd;
                     case (rs_q)
                        ST_DATA: begin
                           rsh_q[ri_q[2:0]] <= rxd;
                           ri_q <= ri_q + 4'h1;
                           if (ri_q == nbits - 4'h1)
                              rs_q <= lcr[`ASPF_LCR_PEN] ? ST_PAR : ST_STOP;
                        end
                        ST_PAR: begin
                           rpe_q <= rxd != par_bit(rsh_q, nbits, lcr);
                           rs_q <= ST_STOP;
                        end
                        default: begin
                           // stop high else frame error; break
                           rx_word <= {!rx_full && 1'b0,
                                       rzero_q && !rxd,
                                       lcr[`ASPF_LCR_PEN] && rpe_q,
                                       !rxd, rsh_q};
                           rx_word[11] <= 1'b0;
                           rx_push <= 1'b1;
                           rdone <= 1'b1;
                           rpe_q <= 1'b0;
                           rs_q <= ST_IDLE;
                        end
                     endcase
                  end
               end
               default: rs_q <= ST_IDLE;
            endcase
         end
      end
   end
   wire overrun = rx_push && rx_full;

   reg [9:0] rto_q;
   always @(posedge mclk_i) begin
      if (!rstn_i || rx_empty || rdone)
         rto_q <= 10'h000;
      else if (oversample_tick && rto_q != 10'h3FF)
         rto_q <= rto_q + 10'h001;
   end
   wire rto_hit = (rto_q == `ASPF_RT_BITS * `ASPF_OVS - 1) && oversample_tick;

   function [AW:0] lvl;
      input [2:0] s;
      reg [31:0] t;
      begin
         case (s)
            3'd0: t = (1 << AW) / 8;
            3'd1: t = (1 << AW) / 4;
            3'd2: t = (1 << AW) / 2;
            3'd3: t = (3 << AW) / 4;
            default: t = (7 << AW) / 8;
         endcase
         lvl = t[AW:0];
      end
   endfunction
   wire [2:0] tx_level_select = fifo_level_select_reg_q[2:0];
   wire [2:0] rx_level_select = fifo_level_select_reg_q[5:3];
   wire tx_lvl = fifo_on ? (tx_cnt <= lvl(tx_level_select)) : tx_empty;
   wire rx_lvl = fifo_on ? (rx_cnt >= lvl(rx_level_select)) : !rx_empty;

   // events and clears; set wins over clear
   wire [10:0] ev;
   assign ev[3:0] = 4'h0;
   assign ev[`ASPF_IRQ_RX] = rx_lvl;
   assign ev[`ASPF_IRQ_TX] = tx_lvl;
   assign ev[`ASPF_IRQ_RT] = rto_hit;
   assign ev[`ASPF_IRQ_FE] = rx_push && rx_word[8];
   assign ev[`ASPF_IRQ_PE] = rx_push && rx_word[9];
   assign ev[`ASPF_IRQ_BE] = rx_push && rx_word[10];
   assign ev[`ASPF_IRQ_OE] = overrun;
   wire [10:0] clr = (wr && paddr_i == `ASPF_OFS_ICR) ? pwdata_i[10:0]
                                                       : 11'h000;
   wire wr_lcr = wr && paddr_i == `ASPF_OFS_LCR;
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         integer_divisor_reg_q <= 16'h0000;
         fraction_divisor_reg_q <= 6'h00;
         line_control_reg_q <= 8'h00;
         work_q <= 30'h0000_0000;
         port_control_reg_q <= `ASPF_CTL_RST;
         fifo_level_select_reg_q <= `ASPF_IFLS_RST;
         irq_mask_reg_q <= 11'h000;
         raw_q <= 11'h000;
         receive_error_reg_q <= 4'h0;
      end else begin
         // clear bit clears raw except rx and tx levels, drain clears timeout
         raw_q <= (raw_q & ~clr) | ev;
         if (rx_empty && !rx_push)
            raw_q[`ASPF_IRQ_RT] <= ev[`ASPF_IRQ_RT];
         raw_q[`ASPF_IRQ_RX] <= rx_lvl;
         raw_q[`ASPF_IRQ_TX] <= tx_lvl;
         if (wr && paddr_i == `ASPF_OFS_RSR)
            receive_error_reg_q <= 4'h0;
         if (rx_push)
            receive_error_reg_q <= receive_error_reg_q |
                                   {overrun, rx_word[10:8]};
         if (wr && paddr_i == `ASPF_OFS_IBRD)
            integer_divisor_reg_q <= pwdata_i[15:0];
         if (wr && paddr_i == `ASPF_OFS_FBRD)
            fraction_divisor_reg_q <= pwdata_i[5:0];
         // working register loads on line control write
         if (wr_lcr) begin
            line_control_reg_q <= pwdata_i[7:0];
            work_q <= {integer_divisor_reg_q, fraction_divisor_reg_q,
                       pwdata_i[7:0]};
         end
         if (wr && paddr_i == `ASPF_OFS_CTL)
            port_control_reg_q <= pwdata_i[15:0] & 16'h0381;
         if (wr && paddr_i == `ASPF_OFS_IFLS)
            fifo_level_select_reg_q <= pwdata_i[5:0];
         if (wr && paddr_i == `ASPF_OFS_IM)
            irq_mask_reg_q <= pwdata_i[10:0] & 11'h7F0;
      end
   end
   wire [10:0] mis = raw_q & irq_mask_reg_q;
   assign irq_o = |mis;

   // read mux
   wire [31:0] flag_reg = {24'h00_0000, !tx_empty, rx_full, tx_full,
                           rx_empty, busy, 3'b000};
   reg [31:0] rmux;
   always @* begin
      case (paddr_i)
         `ASPF_OFS_DATA: rmux = {20'h0_0000, receive_error_reg_q[3] &&
                                 rxf_q[11], rxf_q[10:0]};
         `ASPF_OFS_RSR:  rmux = {28'h000_0000, receive_error_reg_q};
         `ASPF_OFS_FLAG: rmux = flag_reg;
         `ASPF_OFS_IBRD: rmux = {16'h0000, integer_divisor_reg_q};
         `ASPF_OFS_FBRD: rmux = {26'h000_0000, fraction_divisor_reg_q};
         `ASPF_OFS_LCR:  rmux = {24'h00_0000, line_control_reg_q};
         `ASPF_OFS_CTL:  rmux = {16'h0000, port_control_reg_q};
         `ASPF_OFS_IFLS: rmux = {26'h000_0000, fifo_level_select_reg_q};
         `ASPF_OFS_IM:   rmux = {21'h00_0000, irq_mask_reg_q};
         `ASPF_OFS_RIS:  rmux = {21'h00_0000, raw_q};
         `ASPF_OFS_MIS:  rmux = {21'h00_0000, mis};
         default:        rmux = 32'h0000_0000;
      endcase
   end
   always @(posedge mclk_i) begin
      if (!rstn_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i && !penable_i)
         prdata_o <= rmux;
   end
endmodule // aspf_top
`default_nettype wire

/* aspf_chk.sv */
// aspf_chk.sv: pin-level checks for the serial port top.
// assumes a whole divisor of one, so a bit lasts BIT clocks.
`default_nettype none
module aspf_chk #(
   parameter int AW  = 4,
   parameter int BIT = 16
) (
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        serial_out_line_o,
   input wire logic        irq_o
);
   logic [15:0] lo_q, hi_q;
   logic        acc, rd;
   assign acc = psel_i && penable_i;
   assign rd  = acc && !pwrite_i;
   // run lengths of the tx line; reset counts as a long idle
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         lo_q <= 16'h0000;
         hi_q <= 16'hFFFF;
      end else begin
         lo_q <= serial_out_line_o ? 16'h0000 : lo_q + 16'h0001;
         hi_q <= !serial_out_line_o ? 16'h0000 :
                 (hi_q == 16'hFFFF) ? hi_q : hi_q + 16'h0001;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   property p_rdy;
      acc |-> pready_o && !pslverr_o;
   endproperty
   a_rdy: assert property (p_rdy) else $error("apb access stalled");
   property p_unm;
      rd && paddr_i == 12'h100 |-> prdata_o == 32'h0000_0000;
   endproperty
   a_unm: assert property (p_unm) else $error("hole read not zero");
   property p_dat;
      rd && paddr_i == 12'h000 |-> prdata_o[31:12] == 20'h0_0000;
   endproperty
   a_dat: assert property (p_dat)
      else $error("data read wider than 12 bits");
   property p_bsy;
      rd && paddr_i == 12'h018 && prdata_o[7] |-> prdata_o[3];
   endproperty
   a_bsy: assert property (p_bsy)
      else $error("tx holds data but not busy");
   property p_bsl;
      rd && paddr_i == 12'h018 && !$past(serial_out_line_o) |-> prdata_o[3];
   endproperty
   a_bsl: assert property (p_bsl)
      else $error("frame on line but not busy");
   property p_flg;
      rd && paddr_i == 12'h018 |-> !(prdata_o[4] && prdata_o[6]);
   endproperty
   a_flg: assert property (p_flg)
      else $error("rx empty and full together");
   property p_msk;
      acc && pwrite_i && paddr_i == 12'h038 && pwdata_i[10:4] == 7'h00
         |=> !irq_o;
   endproperty
   a_msk: assert property (p_msk)
      else $error("irq with every source masked");
   property p_lo;
      $rose(serial_out_line_o) |-> lo_q != 16'h0000 && lo_q % BIT == 0;
   endproperty
   a_lo: assert property (p_lo)
      else $error("low run not whole bits");
   property p_hi;
      $fell(serial_out_line_o) |-> hi_q >= BIT;
   endproperty
   a_hi: assert property (p_hi)
      else $error("start bit without a full stop before it");
endmodule // aspf_chk
// the bench programs a divisor of one, hence sixteen clocks a bit
bind aspf_top aspf_chk #(.AW(AW), .BIT(16)) chk_u (
   .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .serial_out_line_o(serial_out_line_o),
   .irq_o(irq_o));
`default_nettype wire

/* aspf_remote.sv */
// aspf_remote.sv: remote serial device facing the port's pins.
// assumes BIT clocks a bit; its line idles high between frames.
`default_nettype none
module aspf_remote #(
   parameter int BIT = 16
) (
   input  wire logic        mclk_i,
   input  wire logic        line_i,
   output var  logic        line_o,
   output var  logic [11:0] frm_o
);
   initial begin
      line_o = 1'b1;
      frm_o  = 12'h000;
   end
   // twelve mid-bit samples from the start bit on
   always begin
      @(negedge line_i);
      repeat (BIT / 2) @(posedge mclk_i);
      for (int i = 0; i < 12; i++) begin
         frm_o[i] = line_i;
         repeat (BIT) @(posedge mclk_i);
      end
   end
   task automatic send(input logic [11:0] b, input int nb);
      for (int i = 0; i < nb; i++) begin
         line_o <= b[i];
         repeat (BIT) @(posedge mclk_i);
      end
      line_o <= 1'b1;
   endtask
   task automatic pulse(input int c);
      line_o <= 1'b0;
      repeat (c) @(posedge mclk_i);
      line_o <= 1'b1;
   endtask
endmodule // aspf_remote
`default_nettype wire

/* tb_async_serial_port_fifo.sv */
// tb_async_serial_port_fifo.sv: self-checking bench for the serial port.
// assumes divisor 1.0 (16 clocks a bit) and the remote model on the pins.
`include "aspf_defines.vh"
`default_nettype none
module tb_async_serial_port_fifo;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 16;
   logic        mclk_i, rstn_i, psel, pen, pwr, pready, pslverr, rxl, txl;
   logic        irq;
   logic [11:0] paddr, frm, f;
   logic [31:0] pwdata, prdata, rv;
   int          n_fail, num_checks;
   aspf_top #(.AW(4)) dut_u (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .serial_in_line_i(rxl),
      .serial_out_line_o(txl), .irq_o(irq));
   aspf_remote #(.BIT(BIT)) rem_u (
      .mclk_i(mclk_i), .line_i(txl), .line_o(rxl), .frm_o(frm));
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [11:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, d);
      int k;
      @(posedge mclk_i);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= {20'h0_0000, d};
      @(posedge mclk_i);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rv = prdata;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (k >= 50) begin
         chk("pready", 12'h001, 12'h000);
         conclude();
      end
   endtask
   task automatic wr(input logic [11:0] a, d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, m, e);
      apb(1'b0, a, 12'h000);
      chk(nm, e, rv[11:0] & m);
   endtask
   task automatic poll(input int b, input logic v);
      for (int k = 0; k < 2000; k++) begin
         apb(1'b0, `ASPF_OFS_FLAG, 12'h000);
         if (rv[b] === v)
            return;
      end
      chk("flagwait", {11'h000, v}, {11'h000, rv[b]});
      conclude();
   endtask
   task automatic rdx(input logic [11:0] m, e);
      poll(4, 1'b0);
      rdc("rxword", `ASPF_OFS_DATA, m, e);
   endtask
   task automatic irqc(input logic e);
      // irq follows registers written at the edge, so look mid-cycle
      @(negedge mclk_i);
      chk("irq", {11'h000, e}, {11'h000, irq});
   endtask
   function automatic logic [11:0] frame(input logic [7:0] d, l);
      logic [11:0] r;
      int n;
      n = 5 + int'(l[6:5]);
      r = 12'hFFF;
      r[0] = 1'b0;
      for (int i = 0; i < n; i++)
         r[i + 1] = d[i];
      if (l[1])
         r[n + 1] = l[7] ? !l[2] : ^(d & (8'hFF >> (8 - n))) ^ !l[2];
      return r;
   endfunction
   task automatic s_reset();
      rdc("ctl", `ASPF_OFS_CTL, 12'hFFF, 12'h300);
      rdc("ifls", `ASPF_OFS_IFLS, 12'hFFF, 12'h012);
      rdc("flag", `ASPF_OFS_FLAG, 12'h0F8, 12'h010);
      rdc("ris", `ASPF_OFS_RIS, 12'h7F0, 12'h020);
      wr(12'h100, 12'hABC);
      rdc("hole", 12'h100, 12'hFFF, 12'h000);
   endtask
   task automatic s_fmt();
      logic [7:0] lc [5] = '{8'h0A, 8'h36, 8'hC2, 8'h70, 8'hEE};
      logic [7:0] d;
      d = 8'hB3;
      wr(`ASPF_OFS_IBRD, 12'h001);
      wr(`ASPF_OFS_FBRD, 12'h000);
      wr(`ASPF_OFS_CTL, 12'h301);
      for (int i = 0; i < 5; i++) begin
         wr(`ASPF_OFS_LCR, {4'h0, lc[i]});
         if (i == 2)
            wr(`ASPF_OFS_IBRD, 12'h002);
         wr(`ASPF_OFS_DATA, {4'h0, d});
         rdc("busy", `ASPF_OFS_FLAG, 12'h008, 12'h008);
         if (i == 4) begin
            repeat (3 * BIT) @(posedge mclk_i);
            wr(`ASPF_OFS_CTL, 12'h300);
         end
         poll(3, 1'b0);
         repeat (4 * BIT) @(posedge mclk_i);
         chk("frame", frame(d, lc[i]), frm);
         if (i == 2)
            wr(`ASPF_OFS_IBRD, 12'h001);
         d = d + 8'h35;
      end
      wr(`ASPF_OFS_CTL, 12'h301);
   endtask
   task automatic s_rx();
      wr(`ASPF_OFS_LCR, 12'h076);
      f = frame(8'h5A, 8'h76);
      rem_u.send(f, 11);
      rdx(12'hFFF, 12'h05A);
      rem_u.send(f ^ 12'h200, 11);
      rdx(12'hFFF, 12'h25A);
      rem_u.send(f ^ 12'h400, 11);
      rdx(12'hFFF, 12'h15A);
      rem_u.send(12'h000, 11);
      rdx(12'h4FF, 12'h400);
      rem_u.pulse(BIT / 4);
      repeat (24 * BIT) @(posedge mclk_i);
      rdc("rxempty", `ASPF_OFS_FLAG, 12'h010, 12'h010);
   endtask
   task automatic s_tmo();
      f = frame(8'h81, 8'h76);
      rem_u.send(f, 11);
      poll(4, 1'b0);
      rdc("rt", `ASPF_OFS_RIS, 12'h040, 12'h000);
      repeat (32 * BIT + 40) @(posedge mclk_i);
      rdc("rt", `ASPF_OFS_RIS, 12'h040, 12'h040);
      rdc("mis", `ASPF_OFS_MIS, 12'h040, 12'h000);
      wr(`ASPF_OFS_IM, 12'h040);
      irqc(1'b1);
      rdx(12'hFFF, 12'h081);
      rdc("rt", `ASPF_OFS_RIS, 12'h040, 12'h000);
      rem_u.send(f, 11);
      poll(4, 1'b0);
      repeat (32 * BIT + 40) @(posedge mclk_i);
      irqc(1'b1);
      wr(`ASPF_OFS_ICR, 12'h040);
      irqc(1'b0);
      rdc("rt", `ASPF_OFS_RIS, 12'h040, 12'h000);
      wr(`ASPF_OFS_IM, 12'h000);
      rdx(12'hFFF, 12'h081);
   endtask
   task automatic s_lb();
      wr(`ASPF_OFS_CTL, 12'h381);
      wr(`ASPF_OFS_DATA, 12'h0C3);
      rdx(12'hFFF, 12'h0C3);
      wr(`ASPF_OFS_CTL, 12'h301);
   endtask
   initial begin
      n_fail = 0;
      num_checks = 0;
      rstn_i = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (5) @(posedge mclk_i);
      rstn_i <= 1'b1;
      s_reset();
      s_fmt();
      s_rx();
      s_tmo();
      s_lb();
      conclude();
   end
endmodule // tb_async_serial_port_fifo
`default_nettype wire
